// ---- dv/pwp_guard_fabric.sv ----
// peripheral bus fabric model that issues write-check requests to the guard
module pwp_guard_fabric import pwp_pkg::*; (
  // clock
  input  wire logic       aclk,
  // request from the bench
  input  wire logic       go,
  input  wire logic       grp,
  input  wire logic [4:0] idx,
  // check request towards the guard
  output pwp_guard_req_t  guard_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial guard_req = '{valid: 1'b0, grp: 1'b0, idx: 5'h15};
  // idle cycles toggle group and index so a stale request never looks live
  always @(posedge aclk) begin
    if (go) guard_req <= '{valid: 1'b1, grp: grp, idx: idx};
    else guard_req <= '{valid: 1'b0, grp: ~guard_req.grp, idx: ~guard_req.idx};
  end
endmodule // pwp_guard_fabric

// ---- dv/pwp_peripheral_write_protect_bench.sv ----
// self-checking bench of the peripheral write-protect controller
module pwp_peripheral_write_protect_bench import pwp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic           aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic           go = 1'b0, grp = 1'b0, awr, wr_r, bv, arr, rv, grant, gerr, irq;
  logic [4:0]     idx = 5'h0;
  logic [7:0]     awaddr = 8'h0, araddr = 8'h0;
  logic [3:0]     wstrb = 4'h0;
  logic [1:0]     bresp, rresp;
  logic [31:0]    wdata = 32'h0, rdata, pf0, pf1;
  pwp_guard_req_t greq;
  int             num_errors = 0, checked = 0, st = 0, msk = 0;
  int             g [2] = '{0, 2};
  logic [31:0]    xs = 32'h624601f2;
  logic [3:0]     stb [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  logic [7:0]     wa [4] = '{OFS_G0_CLR, OFS_G0_SET, OFS_G1_CLR, OFS_G1_SET};

  always #5 aclk = ~aclk;

  pwp_peripheral_write_protect dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awaddr), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(araddr), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .guard_req(greq), .guard_grant(grant), .guard_err(gerr),
    .protect_flags_g0(pf0), .protect_flags_g1(pf1), .irq(irq));
  pwp_guard_fabric fab_u (.aclk(aclk), .go(go), .grp(grp), .idx(idx), .guard_req(greq));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // reference write: set and clear act on one shared flag vector per group
  function automatic logic [1:0] mdl_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int gi, m, e;
    if (a == OFS_INT_MASK) begin
      msk = (msk & ~lanes(s)) | (d & lanes(s) & 32'h3);
      return RESP_OKAY;
    end
    // status writes are ignored but answered okay
    if (a == OFS_INT_STAT) return RESP_OKAY;
    if (!(a inside {OFS_G0_CLR, OFS_G0_SET, OFS_G1_CLR, OFS_G1_SET})) return RESP_DECERR;
    gi = a[4];
    m = d & lanes(s) & (gi ? 32'h4e : 32'h7e);
    e = a[2] ? (m & g[gi]) : (m & ~g[gi]);
    g[gi] = a[2] ? (g[gi] | m) : (g[gi] & ~m);
    if (e == 0) return RESP_OKAY;
    st |= 1;
    return RESP_SLVERR;
  endfunction

  function automatic logic [31:0] mdl_rd(input logic [7:0] a);
    int v;
    case (a)
      OFS_G0_CLR, OFS_G0_SET: v = g[0];
      OFS_G1_CLR, OFS_G1_SET: v = g[1];
      OFS_INT_STAT: begin
        v = st;
        st = 0;
      end
      OFS_INT_MASK: v = msk;
      default: v = 0;
    endcase
    return v;
  endfunction

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // both write channels offered together, each released at its own handshake
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    bit dn;
    logic [1:0] r;
    n = 0;
    dn = 0;
    @(posedge aclk);
    awv <= 1'b1;
    awaddr <= a;
    wv <= 1'b1;
    wdata <= d;
    wstrb <= s;
    br <= 1'b1;
    while (!dn && n < 50) begin
      @(posedge aclk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv) begin
        dn = 1;
        r = bresp;
        br <= 1'b0;
      end
    end
    if (!dn) begin
      num_errors++;
      end_of_test();
    end
    chk({30'h0, r}, {30'h0, mdl_wr(a, d, s)});
  endtask

  task automatic rchk(input logic [7:0] a);
    int n;
    bit dn;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    dn = 0;
    @(posedge aclk);
    arv <= 1'b1;
    araddr <= a;
    rr <= 1'b1;
    while (!dn && n < 50) begin
      @(posedge aclk);
      n++;
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        dn = 1;
        d = rdata;
        r = rresp;
        rr <= 1'b0;
      end
    end
    if (!dn) begin
      num_errors++;
      end_of_test();
    end
    chk({30'h0, r}, (a inside {OFS_G0_CLR, OFS_G0_SET, OFS_G1_CLR, OFS_G1_SET, OFS_INT_STAT, OFS_INT_MASK}) ?
        {30'h0, RESP_OKAY} : {30'h0, RESP_DECERR});
    chk(d, mdl_rd(a));
  endtask

  // fabric registers the request, guard answers one cycle after taking it
  task automatic gchk(input logic gp, input logic [4:0] ix);
    int prot;
    prot = (g[gp] >> ix) & 1;
    @(posedge aclk);
    go <= 1'b1;
    grp <= gp;
    idx <= ix;
    @(posedge aclk);
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({30'h0, grant, gerr}, prot ? 32'h1 : 32'h2);
    if (prot) st |= 2;
  endtask

  initial begin
    logic [7:0] a;
    logic [3:0] s;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (wa[k]) rchk(wa[k]);
    rchk(OFS_INT_MASK);
    rchk(8'h08);
    for (int i = 0; i < 60; i++) begin
      xs = xorshift(xs);
      a = wa[xs[1:0]];
      s = stb[int'(xs[4:2]) % 7];
      xs = xorshift(xs);
      wchk(a, xs, s);
      rchk(a ^ 8'h04);
      chk(pf0, g[0]);
      chk(pf1, g[1]);
    end
    wchk(8'h08, 32'hffff_ffff, 4'hf);
    wchk(OFS_G0_SET, 32'h0000_0050, 4'h1);
    for (int i = 0; i < 16; i++) gchk(i[3], {2'h0, i[2:0]});
    chk({31'h0, irq}, 32'h0);
    wchk(OFS_INT_MASK, 32'h3, 4'hf);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, ((st & msk) != 0) ? 32'h1 : 32'h0);
    wchk(OFS_INT_STAT, 32'h3, 4'hf);
    rchk(OFS_INT_STAT);
    rchk(OFS_INT_MASK);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    // a second reset in mid-run must restore the start-up protection
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    g = '{0, 2};
    st = 0;
    msk = 0;
    rchk(OFS_G1_CLR);
    rchk(OFS_G0_SET);
    chk(pf1, G1_RESET);
    end_of_test();
  end
endmodule // pwp_peripheral_write_protect_bench

// ---- hw/pwp_group.sv ----
// one group of protect flags with set and clear masks
module pwp_group import pwp_pkg::*; #(
  parameter logic [31:0] RST_VAL = G0_RESET,
  parameter logic [31:0] IMPL    = G0_IMPL
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // flag updates
  input  wire logic [31:0] set_m,
  input  wire logic [31:0] clr_m,
  // state
  output logic      [31:0] flags_ff
);
  logic [31:0] nxt_flags;

  // R3 R11 masked update
  // unassigned positions never hold a one
  assign nxt_flags = (flags_ff | set_m) & ~clr_m & IMPL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= RST_VAL;
    end else if (ce) begin
      flags_ff <= nxt_flags;
    end
  end
endmodule // pwp_group

// ---- hw/pwp_irq.sv ----
// sticky event status, mask and level interrupt
module pwp_irq import pwp_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // events and software access
  input  wire logic [31:0] events,
  input  wire logic        rd_clr,
  input  wire logic        mask_we,
  input  wire logic [31:0] mask_wm,
  input  wire logic [31:0] mask_wd,
  // state
  output logic      [31:0] stat_ff,
  output logic      [31:0] mask_ff,
  output logic             irq_ff
);
  logic [31:0] nxt_stat;
  logic [31:0] nxt_mask;

  // an event in the clearing read's cycle survives it
  assign nxt_stat = ((rd_clr ? 32'h0 : stat_ff) | events) & INT_IMPL;
  assign nxt_mask = mask_we ? ((mask_ff & ~mask_wm) | (mask_wd & mask_wm)) & INT_IMPL : mask_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= 32'h0;
      mask_ff <= INT_MASK_RST;
      irq_ff  <= 1'b0;
    end else if (ce) begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      irq_ff  <= |(nxt_stat & nxt_mask);
    end
  end
endmodule // pwp_irq

// ---- hw/pwp_peripheral_write_protect.sv ----
// peripheral write-protect controller with axi4-lite register slave
//
// Notes on behaviour
// R1 - registers take atomic 8-, 16- and 32-bit writes from the master.
// R2 - each byte lane and 16-bit half is written alone, other lanes untouched.
// R3 - a zero written to a clear-register bit leaves that protect flag as it is.
// R4 - a one written to a clear-register bit clears the flag; reads give 1 when protected.
// R5 - group 0 clear register resets to 0x000000 with peripherals on bits 1 to 6.
// R6 - group 1 clear register resets to 0x000002, debug unit protected at start.
// R7 - a one written to a set-register bit sets the same shared protect flag.
// R8 - set and clear registers of a group read back the same flag vector.
// R9 - a write aimed at a protected peripheral is dropped and answered with an error.
// R10 - protecting a protected or unprotecting an unprotected peripheral gives an error.
// R11 - unassigned protect positions read zero and ignore writes.
//
// Local design decision: the AXI4-Lite interface to the registers.
module pwp_peripheral_write_protect import pwp_pkg::*; (
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           ce,
  // axi4-lite write address
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [7:0]     s_axi_awaddr,
  // axi4-lite write data
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  // axi4-lite write response
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  output logic [1:0]          s_axi_bresp,
  // axi4-lite read
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  input  wire logic [7:0]     s_axi_araddr,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  // peripheral write guard
  input  wire pwp_guard_req_t guard_req,
  output logic                guard_grant,
  output logic                guard_err,
  // protect state and interrupt
  output logic [31:0]         protect_flags_g0,
  output logic [31:0]         protect_flags_g1,
  output logic                irq
);
  logic        awready_ff, wready_ff, arready_ff;
  logic        aw_hold_ff, w_hold_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bvalid_ff, rvalid_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic        guard_grant_ff, guard_err_ff;
  logic [31:0] g0_flags, g1_flags, stat, mask;
  logic        irq_ff;

  // handshakes
  wire aw_fire = s_axi_awvalid & awready_ff;
  wire w_fire  = s_axi_wvalid & wready_ff;
  wire ar_fire = s_axi_arvalid & arready_ff;
  wire b_fire  = bvalid_ff & s_axi_bready;
  wire r_fire  = rvalid_ff & s_axi_rready;
  // both halves of a write are held; act once
  wire wr_go   = aw_hold_ff & w_hold_ff & ~bvalid_ff;

  // write decode
  wire pwp_sel_t    wsel  = pwp_decode(aw_addr_ff);
  wire logic [31:0] lane  = pwp_lane_mask(w_strb_ff);
  wire logic [31:0] wdat  = w_data_ff & lane;
  // R2 lane gating
  wire logic [31:0] g0_clr = (wr_go && wsel == SEL_G0_CLR) ? wdat & G0_IMPL : 32'h0;
  wire logic [31:0] g0_set = (wr_go && wsel == SEL_G0_SET) ? wdat & G0_IMPL : 32'h0;
  wire logic [31:0] g1_clr = (wr_go && wsel == SEL_G1_CLR) ? wdat & G1_IMPL : 32'h0;
  wire logic [31:0] g1_set = (wr_go && wsel == SEL_G1_SET) ? wdat & G1_IMPL : 32'h0;
  // R10 double protect or unprotect
  wire dbl_err = |((g0_set & g0_flags) | (g0_clr & ~g0_flags)
                 | (g1_set & g1_flags) | (g1_clr & ~g1_flags));
  wire unmapped = wsel == SEL_NONE;
  wire logic [1:0] nxt_bresp = unmapped ? RESP_DECERR : (dbl_err ? RESP_SLVERR : RESP_OKAY);

  // read decode
  wire pwp_sel_t rsel = pwp_decode(s_axi_araddr);
  // R8 same vector on set and clear
  wire logic [31:0] rd_word =
      (rsel == SEL_G0_CLR || rsel == SEL_G0_SET) ? g0_flags :
      (rsel == SEL_G1_CLR || rsel == SEL_G1_SET) ? g1_flags :
      (rsel == SEL_STAT) ? stat :
      (rsel == SEL_MASK) ? mask : 32'h0;
  wire logic [1:0] nxt_rresp = (rsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;

  // R9 guard lookup of the addressed protect flag
  wire logic [31:0] guard_vec = guard_req.grp ? g1_flags : g0_flags;
  wire              guard_prot = guard_vec[guard_req.idx];

  wire logic [31:0] events = ({31'h0, dbl_err} << INT_DBL_BIT)
                           | ({31'h0, guard_req.valid & guard_prot} << INT_GUARD_BIT);

  // R4 R5 R7 group 0 flags
  pwp_group #(.RST_VAL(G0_RESET), .IMPL(G0_IMPL)) u_g0 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .set_m    (g0_set),
    .clr_m    (g0_clr),
    .flags_ff (g0_flags)
  );
  // R6 group 1 flags
  pwp_group #(.RST_VAL(G1_RESET), .IMPL(G1_IMPL)) u_g1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .set_m    (g1_set),
    .clr_m    (g1_clr),
    .flags_ff (g1_flags)
  );

  pwp_irq u_irq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .events  (events),
    .rd_clr  (ar_fire && rsel == SEL_STAT),
    .mask_we (wr_go && wsel == SEL_MASK),
    .mask_wm (lane),
    .mask_wd (w_data_ff),
    .stat_ff (stat),
    .mask_ff (mask),
    .irq_ff  (irq_ff)
  );

  // R1 word capture
  // write channel capture; readies drop after a take, return when the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      aw_addr_ff <= 8'h0;
      w_data_ff  <= 32'h0;
      w_strb_ff  <= 4'h0;
    end else if (ce) begin
      if (aw_fire) begin
        aw_hold_ff <= 1'b1;
        awready_ff <= 1'b0;
        aw_addr_ff <= s_axi_awaddr;
      end else if (b_fire) begin
        aw_hold_ff <= 1'b0;
        awready_ff <= 1'b1;
      end
      if (w_fire) begin
        w_hold_ff <= 1'b1;
        wready_ff <= 1'b0;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (b_fire) begin
        w_hold_ff <= 1'b0;
        wready_ff <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= nxt_bresp;
      end else if (b_fire) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read channel: one outstanding read, data sampled at the address take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= rd_word;
        rresp_ff   <= nxt_rresp;
      end else if (r_fire) begin
        arready_ff <= 1'b1;
        rvalid_ff  <= 1'b0;
      end
    end
  end

  // R9 guard verdict one cycle after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      guard_grant_ff <= 1'b0;
      guard_err_ff   <= 1'b0;
    end else if (ce) begin
      guard_grant_ff <= guard_req.valid & ~guard_prot;
      guard_err_ff   <= guard_req.valid & guard_prot;
    end
  end

  assign s_axi_awready    = awready_ff;
  assign s_axi_wready     = wready_ff;
  assign s_axi_arready    = arready_ff;
  assign s_axi_bvalid     = bvalid_ff;
  assign s_axi_bresp      = bresp_ff;
  assign s_axi_rvalid     = rvalid_ff;
  assign s_axi_rdata      = rdata_ff;
  assign s_axi_rresp      = rresp_ff;
  assign guard_grant      = guard_grant_ff;
  assign guard_err        = guard_err_ff;
  assign protect_flags_g0 = g0_flags;
  assign protect_flags_g1 = g1_flags;
  assign irq              = irq_ff;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // R1 group 0 clear
  AST_CLR_EFFECT: assert property (wr_go && ce && |g0_clr |=> // R1 R4
      (g0_flags & $past(g0_clr)) == 32'h0)
    else $error("cleared protect bit still set");
  // R7 set effect
  AST_SET_EFFECT: assert property (wr_go && ce && |g1_set |=> // R7
      (g1_flags & $past(g1_set)) == $past(g1_set))
    else $error("set protect bit not set");
  // R3 zero keeps
  AST_ZERO_KEEPS: assert property (ce && g0_set == 32'h0 |=> // R3
      ((g0_flags ^ $past(g0_flags)) & ~$past(g0_clr)) == 32'h0)
    else $error("protect flag changed without a one written");
  // R2 lane gating
  AST_LANE_ONLY: assert property (wr_go && ce && !w_strb_ff[0] |=> // R2
      g0_flags[7:0] == $past(g0_flags[7:0]) && g1_flags[7:0] == $past(g1_flags[7:0]))
    else $error("unselected byte lane changed");
  // R5 group 0 reset
  AST_G0_RESET: assert property (disable iff (1'b0) !aresetn |=> g0_flags == G0_RESET) // R5
    else $error("group 0 reset value wrong");
  // R6 group 1 reset
  AST_G1_RESET: assert property (disable iff (1'b0) !aresetn |=> g1_flags == G1_RESET) // R6
    else $error("group 1 reset value wrong");
  // R8 read match
  AST_RD_SAME: assert property (ar_fire && ce && (rsel == SEL_G1_CLR || rsel == SEL_G1_SET) |=> // R8
      s_axi_rvalid && s_axi_rdata == $past(g1_flags))
    else $error("group read does not match flags");
  // R9 guard refuse
  AST_GUARD_ERR: assert property (ce && guard_req.valid && guard_prot |=> // R9
      guard_err && !guard_grant && stat[INT_GUARD_BIT])
    else $error("protected write not refused");
  // R10 double error
  AST_DBL_ERR: assert property (wr_go && ce && !unmapped && dbl_err |=> // R10
      s_axi_bvalid && s_axi_bresp == RESP_SLVERR && stat[INT_DBL_BIT])
    else $error("double protect not answered with error");
  // R11 unused positions
  AST_UNUSED_ZERO: assert property ((g0_flags & ~G0_IMPL) == 32'h0 && (g1_flags & ~G1_IMPL) == 32'h0) // R11
    else $error("unassigned protect bit set");
  // R4 group 1 clear
  AST_CLR_G1: assert property (wr_go && ce && |g1_clr |=> // R4
      (g1_flags & $past(g1_clr)) == 32'h0)
    else $error("cleared group 1 protect bit still set");
  // R7 group 0 set
  AST_SET_G0: assert property (wr_go && ce && |g0_set |=> // R7
      (g0_flags & $past(g0_set)) == $past(g0_set))
    else $error("group 0 protect bit not set");
  // R3 group 1 keeps
  AST_ZERO_KEEPS_G1: assert property (ce && g1_set == 32'h0 |=> // R3
      ((g1_flags ^ $past(g1_flags)) & ~$past(g1_clr)) == 32'h0)
    else $error("group 1 flag changed without a one written");
  // R9 guard grant
  AST_GUARD_OK: assert property (ce && guard_req.valid && !guard_prot |=> guard_grant && !guard_err) // R9
    else $error("unprotected write not granted");
  // R9 guard quiet
  AST_GUARD_IDLE: assert property (ce && !guard_req.valid |=> !guard_grant && !guard_err) // R9
    else $error("guard verdict without a request");
  // R10 clean write
  AST_WR_OKAY: assert property (wr_go && ce && !unmapped && !dbl_err |=> s_axi_bresp == RESP_OKAY) // R10
    else $error("clean write not answered okay");
  // R11 unmapped write
  AST_WR_UNMAPPED: assert property (wr_go && ce && unmapped |=> // R11
      s_axi_bresp == RESP_DECERR && g0_flags == $past(g0_flags) && g1_flags == $past(g1_flags))
    else $error("unmapped write changed state or not refused");
  // R1 address take
  AST_AW_TAKE: assert property (aw_fire && ce |=> !s_axi_awready) // R1
    else $error("write address ready still high after take");
  // R1 data take
  AST_W_TAKE: assert property (w_fire && ce |=> !s_axi_wready) // R1
    else $error("write data ready still high after take");
  // R1 response offered
  AST_B_OFFER: assert property (wr_go && ce |=> s_axi_bvalid) // R1
    else $error("write response not offered after both halves held");
  // R8 read take
  AST_AR_TAKE: assert property (ar_fire && ce |=> s_axi_rvalid && !s_axi_arready) // R8
    else $error("read data not offered after address take");
  // R8 read done
  AST_R_DONE: assert property (r_fire && ce |=> !s_axi_rvalid && s_axi_arready) // R8
    else $error("read channel not released after data take");
  // R9 R10 irq level
  AST_IRQ_LEVEL: assert property (ce |=> irq == |(stat & mask)) // R9 R10
    else $error("interrupt level disagrees with status and mask");

  COV_G0_CLEAR:  cover property (wr_go && ce && |g0_clr);
  COV_GUARD_ERR: cover property (guard_err);
  COV_DBL_ERR:   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  COV_IRQ:       cover property ($rose(irq));
endmodule // pwp_peripheral_write_protect

// ---- hw/pwp_pkg.sv ----
// shared constants, types and helpers of the peripheral write-protect block
package pwp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_G0_CLR   = 8'h00;
  localparam logic [7:0] OFS_G0_SET   = 8'h04;
  localparam logic [7:0] OFS_G1_CLR   = 8'h10;
  localparam logic [7:0] OFS_G1_SET   = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h20;
  localparam logic [7:0] OFS_INT_MASK = 8'h24;
  // reset values and implemented protect bits
  localparam logic [31:0] G0_RESET = 32'h0000_0000;
  localparam logic [31:0] G1_RESET = 32'h0000_0002;
  localparam logic [31:0] G0_IMPL  = 32'h0000_007e;
  localparam logic [31:0] G1_IMPL  = 32'h0000_004e;
  // group 0 bit positions
  localparam int G0_POWER_MANAGER        = 1;
  localparam int G0_OSCILLATOR_CTRL      = 2;
  localparam int G0_GENERIC_CLOCK_CTRL   = 3;
  localparam int G0_WATCHDOG_TIMER       = 4;
  localparam int G0_CALENDAR_COUNTER     = 5;
  localparam int G0_EXTERNAL_INTERRUPT   = 6;
  // group 1 bit positions
  localparam int G1_DEBUG_SERVICE_UNIT   = 1;
  localparam int G1_FLASH_MEMORY_CTRL    = 2;
  localparam int G1_PIN_IO_CTRL          = 3;
  localparam int G1_TRACE_BUFFER         = 6;
  // interrupt status bits
  localparam int             INT_DBL_BIT   = 0;
  localparam int             INT_GUARD_BIT = 1;
  localparam logic [31:0]    INT_IMPL      = 32'h0000_0003;
  localparam logic [31:0]    INT_MASK_RST  = 32'h0000_0000;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_G0_CLR, SEL_G0_SET, SEL_G1_CLR, SEL_G1_SET, SEL_STAT, SEL_MASK
  } pwp_sel_t;

  // write check request from the peripheral bus fabric
  typedef struct packed {
    logic       valid;
    logic       grp;
    logic [4:0] idx;
  } pwp_guard_req_t;

  function automatic pwp_sel_t pwp_decode(input logic [7:0] a);
    if (a == OFS_G0_CLR) return SEL_G0_CLR;
    else if (a == OFS_G0_SET) return SEL_G0_SET;
    else if (a == OFS_G1_CLR) return SEL_G1_CLR;
    else if (a == OFS_G1_SET) return SEL_G1_SET;
    else if (a == OFS_INT_STAT) return SEL_STAT;
    else if (a == OFS_INT_MASK) return SEL_MASK;
    else return SEL_NONE;
  endfunction

  function automatic logic [31:0] pwp_lane_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
endpackage
